/* hdl/ftc_regs.svh */
`ifndef FTC_REGS_SVH
`define FTC_REGS_SVH

// register addresses on the one-wire frame
`define FTC_ADDR_FLASH    8'h01
`define FTC_ADDR_TORCH    8'h02
`define FTC_ADDR_SAFETY   8'h03
`define FTC_ADDR_BATT     8'h04

// largest legal data word per register
`define FTC_MAX_FLASH     8'h1f
`define FTC_MAX_TORCH     8'h1f
`define FTC_MAX_SAFETY    8'h07
`define FTC_MAX_BATT      8'h09

// field positions of the enable/current registers
`define FTC_EN_BIT        4
`define FTC_CODE_MSB      3
`define FTC_CODE_LSB      0

// reset values
`define FTC_RST_LED_EN    1'h0
`define FTC_RST_LED_CODE  4'h0
`define FTC_RST_SAFETY    3'h7
`define FTC_RST_BATT      4'h7

// timing: safety step 156.25 ms in microseconds, 1 us tick at 10 ns clock
`define FTC_CLK_NS        10
`define FTC_TICK_NS       1000
`define FTC_TICK_CYC      (`FTC_TICK_NS / `FTC_CLK_NS)
`define FTC_STEP_US       156250

// low-battery threshold: code 1 is 3.0 V, 100 mV per code
`define FTC_BATT_BASE_MV  12'hbb8
`define FTC_BATT_STEP_MV  12'h064
`define FTC_BATT_OFF      4'h0

`endif

/* hdl/ftc_pkg.sv */
`default_nettype none
package ftc_pkg;

  typedef struct packed {
    logic       en;
    logic [3:0] code;
  } ftc_led_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } ftc_wr_t;

  typedef enum logic [1:0] {
    TMR_IDLE    = 2'b00,
    TMR_RUN     = 2'b01,
    TMR_EXPIRED = 2'b10
  } ftc_tmr_t;

  typedef struct packed {
    ftc_led_t    flash;
    ftc_led_t    torch;
    logic [2:0]  safety;
    logic [3:0]  batt;
    logic [13:0] flash_pct;
    logic [13:0] torch_pct;
    logic [20:0] timeout_us;
    logic [11:0] batt_mv;
    logic        low_batt;
    ftc_tmr_t    tmr;
    logic [15:0] tick_cnt;
    logic [20:0] elapsed_us;
    logic        flash_on;
    logic        torch_on;
    logic        accept;
    logic        reject;
  } ftc_state_t;

endpackage
`default_nettype wire

/* hdl/ftc_level_lut.sv */
`default_nettype none
module ftc_level_lut (
  input  wire logic [3:0]  code_i, // current code
  output logic      [13:0] pct_o   // percent of max current, x100
);
  always_comb begin
    unique case (code_i)
      4'h0: pct_o = 14'd10000;
      4'h1: pct_o = 14'd8896;
      4'h2: pct_o = 14'd7904;
      4'h3: pct_o = 14'd7072;
      4'h4: pct_o = 14'd6304;
      4'h5: pct_o = 14'd5600;
      4'h6: pct_o = 14'd4992;
      4'h7: pct_o = 14'd4464;
      4'h8: pct_o = 14'd3968;
      4'h9: pct_o = 14'd3552;
      4'ha: pct_o = 14'd3168;
      4'hb: pct_o = 14'd2816;
      4'hc: pct_o = 14'd2512;
      4'hd: pct_o = 14'd2240;
      4'he: pct_o = 14'd2000;
      4'hf: pct_o = 14'd1792;
    endcase
  end
endmodule
`default_nettype wire

/* hdl/ftc_ctrl_regs.sv */
// What this block does
// [R01] flash values 0-15 store level, flash off
// [R02] flash values 16-31 store level, enable flash
// [R03] flash bit 4 enable, bits 3:0 code
// [R04] code maps to percent table, 100.00 to 17.92
// [R05] flash register resets to zero
// [R06] torch values 0-15 store level, torch off
// [R07] torch values 16-31 store level, enable torch
// [R08] torch enable zero keeps torch off
// [R09] torch bit 4 enable, same percent table
// [R10] torch register resets to zero
// [R11] safety timer limits on-time above threshold
// [R12] duration code n gives (n+1) x 156.25 ms
// [R13] safety duration resets to code 7
// [R14] below battery threshold: flag, inhibit flash
// [R15] battery code zero disables detection
// [R16] battery codes 1-9 give 3.0-3.8 V
// [R17] battery threshold resets to code 7
// [R18] over-maximum writes rejected, frame discarded
// [R19] registers addressed 1 to 4
// [R20] write-only, defaults on shutdown
// [R21] decoded outputs change only on accepted write or shutdown
`include "ftc_regs.svh"
`default_nettype none
module ftc_ctrl_regs #(
  parameter int unsigned TICK_CYC = `FTC_TICK_CYC,
  parameter logic [20:0] STEP_US  = 21'(`FTC_STEP_US)
) (
  input  wire logic             clk_i,            // 100 MHz clock
  input  wire logic             rst_b_i,          // async reset, active low
  input  wire logic             shutdown_i,       // shutdown state, level
  input  wire ftc_pkg::ftc_wr_t wr_i,             // latched frame from decoder
  input  wire logic [11:0]      supply_mv_i,      // supply voltage, mV
  input  wire logic             over_thresh_i,    // LED current above threshold
  output ftc_pkg::ftc_led_t     flash_o,          // flash enable and code
  output ftc_pkg::ftc_led_t     torch_o,          // torch enable and code
  output logic [13:0]           flash_pct_o,      // flash level, % x100
  output logic [13:0]           torch_pct_o,      // torch level, % x100
  output logic [2:0]            safety_code_o,    // duration code
  output logic [20:0]           timeout_us_o,     // time-out, us
  output logic [3:0]            batt_code_o,      // battery threshold code
  output logic [11:0]           batt_mv_o,        // threshold, mV (0 off)
  output logic                  low_batt_o,       // low-battery flag
  output logic                  flash_on_o,       // flash allowed to run
  output logic                  torch_on_o,       // torch running
  output logic                  safety_expired_o, // safety timer ran out
  output logic                  wr_accept_o,      // frame accepted pulse
  output logic                  wr_reject_o       // frame discarded pulse
);
  import ftc_pkg::*;

  ftc_state_t  st_q;
  ftc_state_t  st_d;
  logic [13:0] flash_pct_w;
  logic [13:0] torch_pct_w;
  logic [3:0]  lut_code [2];
  logic [13:0] lut_pct [2];

  function automatic logic [7:0] reg_max(input logic [7:0] addr);
    unique case (addr)
      `FTC_ADDR_FLASH:  reg_max = `FTC_MAX_FLASH;
      `FTC_ADDR_TORCH:  reg_max = `FTC_MAX_TORCH;
      `FTC_ADDR_SAFETY: reg_max = `FTC_MAX_SAFETY;
      default:          reg_max = `FTC_MAX_BATT;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [7:0] addr);
    addr_ok = (addr >= `FTC_ADDR_FLASH) && (addr <= `FTC_ADDR_BATT); // [R19]
  endfunction

  assign lut_code[0] = st_d.flash.code;
  assign lut_code[1] = st_d.torch.code;
  assign flash_pct_w = lut_pct[0];
  assign torch_pct_w = lut_pct[1];

  // same table for flash and torch
  for (genvar i = 0; i < 2; i++) begin : g_lut
    ftc_level_lut u_lut (
      .code_i (lut_code[i]),
      .pct_o  (lut_pct[i])
    ); // [R04] [R09]
  end

  always_comb begin
    logic       ok;
    logic       tick;
    logic       active;
    ok     = 1'b0;
    tick   = 1'b0;
    active = 1'b0;
    st_d   = st_q;
    st_d.accept = 1'b0;
    st_d.reject = 1'b0;

    // write path: only whole legal frames update state
    if (wr_i.valid && !shutdown_i) begin
      ok = addr_ok(wr_i.addr) && (wr_i.data <= reg_max(wr_i.addr)); // [R18]
      st_d.accept = ok;
      st_d.reject = !ok; // [R18]
      if (ok) begin
        unique case (wr_i.addr)
          `FTC_ADDR_FLASH: begin
            st_d.flash.en   = wr_i.data[`FTC_EN_BIT]; // [R01] [R02] [R03]
            st_d.flash.code = wr_i.data[`FTC_CODE_MSB:`FTC_CODE_LSB]; // [R03]
          end
          `FTC_ADDR_TORCH: begin
            st_d.torch.en   = wr_i.data[`FTC_EN_BIT]; // [R06] [R07] [R09]
            st_d.torch.code = wr_i.data[`FTC_CODE_MSB:`FTC_CODE_LSB]; // [R09]
          end
          `FTC_ADDR_SAFETY: st_d.safety = wr_i.data[2:0];
          default:          st_d.batt   = wr_i.data[3:0];
        endcase
      end
    end

    // shutdown holds every register at default
    if (shutdown_i) begin
      st_d.flash.en   = `FTC_RST_LED_EN; // [R05] [R20]
      st_d.flash.code = `FTC_RST_LED_CODE; // [R05]
      st_d.torch.en   = `FTC_RST_LED_EN; // [R10] [R20]
      st_d.torch.code = `FTC_RST_LED_CODE; // [R10]
      st_d.safety     = `FTC_RST_SAFETY; // [R13]
      st_d.batt       = `FTC_RST_BATT; // [R17]
    end

    // decoded views follow the stored values on the same edge
    st_d.flash_pct  = flash_pct_w; // [R21]
    st_d.torch_pct  = torch_pct_w; // [R21]
    st_d.timeout_us = 21'(({18'h0, st_d.safety} + 21'h1) * STEP_US); // [R12]
    if (st_d.batt == `FTC_BATT_OFF) begin
      st_d.batt_mv = 12'h0; // [R15]
    end else begin
      st_d.batt_mv = 12'(`FTC_BATT_BASE_MV
                   + 12'(st_d.batt - 4'h1) * `FTC_BATT_STEP_MV); // [R16]
    end

    // low-battery compare; code zero never flags
    st_d.low_batt = (st_q.batt != `FTC_BATT_OFF)
                  && (supply_mv_i < st_q.batt_mv); // [R14] [R15]

    // 1 us tick divider
    if (st_q.tick_cnt >= 16'(TICK_CYC - 1)) begin
      st_d.tick_cnt = 16'h0;
      tick = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 16'h1;
    end

    // safety timer only runs while current is over threshold
    active = (st_q.flash.en || st_q.torch.en) && over_thresh_i; // [R11]
    unique case (st_q.tmr)
      TMR_IDLE: begin
        st_d.elapsed_us = 21'h0;
        if (active) begin
          st_d.tmr = TMR_RUN;
        end
      end
      TMR_RUN: begin
        if (!active) begin
          st_d.tmr = TMR_IDLE;
        end else if (tick) begin
          st_d.elapsed_us = st_q.elapsed_us + 21'h1;
          if (st_q.elapsed_us + 21'h1 >= st_q.timeout_us) begin
            st_d.tmr = TMR_EXPIRED; // [R11]
          end
        end
      end
      TMR_EXPIRED: begin
        if (!st_q.flash.en && !st_q.torch.en) begin
          st_d.tmr = TMR_IDLE;
        end
      end
      default: st_d.tmr = TMR_IDLE;
    endcase
    if (shutdown_i) begin
      st_d.tmr = TMR_IDLE;
    end

    st_d.flash_on = st_q.flash.en && !st_q.low_batt
                  && (st_q.tmr != TMR_EXPIRED); // [R14] [R11]
    st_d.torch_on = st_q.torch.en && (st_q.tmr != TMR_EXPIRED); // [R08] [R11]
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '{flash: '{`FTC_RST_LED_EN, `FTC_RST_LED_CODE},
                torch: '{`FTC_RST_LED_EN, `FTC_RST_LED_CODE},
                safety: `FTC_RST_SAFETY,
                batt: `FTC_RST_BATT,
                flash_pct: 14'd10000,
                torch_pct: 14'd10000,
                timeout_us: 21'((21'(`FTC_RST_SAFETY) + 21'h1) * STEP_US),
                batt_mv: 12'he10,
                tmr: TMR_IDLE,
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign flash_o          = st_q.flash;
  assign torch_o          = st_q.torch;
  assign flash_pct_o      = st_q.flash_pct;
  assign torch_pct_o      = st_q.torch_pct;
  assign safety_code_o    = st_q.safety;
  assign timeout_us_o     = st_q.timeout_us;
  assign batt_code_o      = st_q.batt;
  assign batt_mv_o        = st_q.batt_mv;
  assign low_batt_o       = st_q.low_batt;
  assign flash_on_o       = st_q.flash_on;
  assign torch_on_o       = st_q.torch_on;
  assign safety_expired_o = st_q.tmr[1]; // only the expired code has bit 1 set
  assign wr_accept_o      = st_q.accept;
  assign wr_reject_o      = st_q.reject;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_good_wr(logic [7:0] a);
    wr_i.valid && !shutdown_i && wr_i.addr == a;
  endsequence

  sequence s_bad_wr;
    wr_i.valid && !shutdown_i && (!addr_ok(wr_i.addr)
      || wr_i.data > reg_max(wr_i.addr));
  endsequence

  AST_FLASH_LOW: assert property (s_good_wr(`FTC_ADDR_FLASH) and wr_i.data < 8'h10 // [R01]
    |=> !flash_o.en && flash_o.code == $past(wr_i.data[3:0]) && wr_accept_o)
    else $error("flash low write set enable");
  AST_FLASH_HIGH: assert property (s_good_wr(`FTC_ADDR_FLASH) and wr_i.data >= 8'h10 // [R02]
    and wr_i.data <= `FTC_MAX_FLASH |=> flash_o.en && flash_o.code == $past(wr_i.data[3:0]))
    else $error("flash high write missed enable");
  AST_TORCH_WR: assert property (s_good_wr(`FTC_ADDR_TORCH) // [R09]
    and wr_i.data <= `FTC_MAX_TORCH
    |=> torch_o.en == $past(wr_i.data[4]) && torch_o.code == $past(wr_i.data[3:0]))
    else $error("torch write split wrong");
  AST_PCT_ENDS: assert property ((flash_o.code == 4'h0 |-> flash_pct_o == 14'd10000) // [R04]
    and (torch_o.code == 4'hf |-> torch_pct_o == 14'd1792))
    else $error("percent table end wrong");
  AST_SHUTDOWN: assert property (shutdown_i |=> flash_o == '0 && torch_o == '0 // [R20]
    && safety_code_o == 3'h7 && batt_code_o == 4'h7 && !wr_accept_o)
    else $error("shutdown defaults wrong");
  AST_TORCH_OFF: assert property (!torch_o.en |=> !torch_on_o) // [R08]
    else $error("torch on without enable");
  AST_TIMEOUT: assert property (timeout_us_o // [R12]
    == 21'(({18'h0, safety_code_o} + 21'h1) * STEP_US))
    else $error("timeout decode wrong");
  AST_BATT_MV: assert property (batt_code_o == 4'h1 |-> batt_mv_o == 12'd3000) // [R16]
    else $error("battery base threshold wrong");
  AST_BATT_OFF: assert property (batt_code_o == `FTC_BATT_OFF [*2] |-> !low_batt_o) // [R15]
    else $error("low battery flagged while disabled");
  AST_LB_INHIBIT: assert property (low_batt_o |=> !flash_on_o) // [R14]
    else $error("flash on under low battery");
  AST_REJECT: assert property (s_bad_wr |=> wr_reject_o && $stable(flash_o) // [R18]
    && $stable(torch_o) && $stable(safety_code_o) && $stable(batt_code_o))
    else $error("bad frame not discarded");
  AST_EXPIRE: assert property (safety_expired_o |=> !flash_on_o && !torch_on_o) // [R11]
    else $error("led on after safety expiry");
  AST_STEADY: assert property (!wr_i.valid && !shutdown_i |=> $stable(flash_pct_o) // [R21]
    && $stable(timeout_us_o) && $stable(batt_mv_o))
    else $error("decoded output moved without write");

endmodule
`default_nettype wire

/* sim/ftc_host_model.sv */
`default_nettype none
module ftc_host_model (
  input  wire logic            clk_i, // device clock
  output var ftc_pkg::ftc_wr_t wr_o   // frame to the register bank
);
  timeunit 1ns;
  timeprecision 1ps;
  import ftc_pkg::*;

  initial wr_o = '{valid: 1'b0, addr: 8'h00, data: 8'h00};

  // one whole frame per edge; valid stays up for back-to-back frames
  task automatic send(input logic [7:0] a, input logic [7:0] d);
    wr_o = '{valid: 1'b1, addr: a, data: d};
    @(posedge clk_i);
    #1;
  endtask

  // released frame never repeats the last word
  task automatic idle();
    wr_o = '{valid: 1'b0, addr: ~wr_o.addr, data: ~wr_o.data};
  endtask
endmodule
`default_nettype wire

/* sim/ftc_ctrl_regs_tb.sv */
`default_nettype none
module ftc_ctrl_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ftc_pkg::*;

  typedef struct packed {
    logic        rej;
    logic [4:0]  fl;
    logic [4:0]  to;
    logic [13:0] fp;
    logic [13:0] tp;
    logic [2:0]  sd;
    logic [20:0] tmo;
    logic [3:0]  bt;
    logic [11:0] mv;
  } ftc_exp_t;

  localparam logic [20:0] STEP = 21'h000004;
  localparam logic [13:0] PCT [16] = '{14'h2710, 14'h22c0, 14'h1ee0, 14'h1ba0,
    14'h18a0, 14'h15e0, 14'h1380, 14'h1170, 14'h0f80, 14'h0de0, 14'h0c60,
    14'h0b00, 14'h09d0, 14'h08c0, 14'h07d0, 14'h0700};

  logic        clk_i, rst_b_i, shutdown_i, over_thresh_i;
  logic [11:0] supply_mv_i, batt_mv_o;
  ftc_wr_t     wr;
  ftc_led_t    flash_o, torch_o;
  logic [13:0] flash_pct_o, torch_pct_o;
  logic [2:0]  safety_code_o;
  logic [20:0] timeout_us_o;
  logic [3:0]  batt_code_o, m_bt;
  logic        low_batt_o, flash_on_o, torch_on_o, safety_expired_o;
  logic        wr_accept_o, wr_reject_o;
  logic [4:0]  m_fl, m_to;
  logic [2:0]  m_sd;
  int          num_errors, n_compared, seed, n;
  ftc_exp_t    q[$];

  ftc_host_model host (.clk_i(clk_i), .wr_o(wr));

  ftc_ctrl_regs #(.TICK_CYC(1), .STEP_US(STEP)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .shutdown_i(shutdown_i), .wr_i(wr),
    .supply_mv_i(supply_mv_i), .over_thresh_i(over_thresh_i), .flash_o(flash_o),
    .torch_o(torch_o), .flash_pct_o(flash_pct_o), .torch_pct_o(torch_pct_o),
    .safety_code_o(safety_code_o), .timeout_us_o(timeout_us_o),
    .batt_code_o(batt_code_o), .batt_mv_o(batt_mv_o), .low_batt_o(low_batt_o),
    .flash_on_o(flash_on_o), .torch_on_o(torch_on_o),
    .safety_expired_o(safety_expired_o), .wr_accept_o(wr_accept_o),
    .wr_reject_o(wr_reject_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic ftc_exp_t snap(input logic r);
    logic [11:0] mv;
    mv = (m_bt == 4'h0) ? 12'h000 : 12'hbb8 + 12'h064 * 12'(m_bt - 4'h1);
    return '{r, m_fl, m_to, PCT[m_fl[3:0]], PCT[m_to[3:0]], m_sd,
             (21'(m_sd) + 21'h000001) * STEP, m_bt, mv};
  endfunction

  function automatic ftc_exp_t got();
    return '{wr_reject_o, flash_o, torch_o, flash_pct_o, torch_pct_o,
             safety_code_o, timeout_us_o, batt_code_o, batt_mv_o};
  endfunction

  task automatic chk_frame(input ftc_exp_t g, input ftc_exp_t e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rst_model();
    m_fl = 5'h00;
    m_to = 5'h00;
    m_sd = 3'h7;
    m_bt = 4'h7;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    ok = (a == 8'h01 || a == 8'h02) ? d <= 8'h1f : (a == 8'h03) ? d <= 8'h07 :
         (a == 8'h04) ? d <= 8'h09 : 1'b0;
    if (ok) begin
      case (a)
        8'h01: m_fl = d[4:0];
        8'h02: m_to = d[4:0];
        8'h03: m_sd = d[2:0];
        default: m_bt = d[3:0];
      endcase
    end
    q.push_back(snap(!ok));
    host.send(a, d);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // every accept or reject pulse takes the oldest note
  always @(negedge clk_i) begin
    if (wr_accept_o === 1'b1 || wr_reject_o === 1'b1) begin
      if (q.size() == 0) chk_bit(1'b1, 1'b0);
      else chk_frame(got(), q.pop_front());
    end
  end

  initial begin
    seed = 26930;
    num_errors = 0;
    n_compared = 0;
    rst_b_i = 1'b0;
    shutdown_i = 1'b0;
    over_thresh_i = 1'b0;
    supply_mv_i = 12'hfa0;
    rst_model();
    repeat (5) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    chk_frame(got(), snap(1'b0));
    $display("test reset done");
    for (int i = 0; i < 32; i++) wr_reg(8'h01, 8'(i));
    for (int i = 0; i < 32; i++) wr_reg(8'h02, 8'(i));
    for (int i = 0; i < 8; i++) wr_reg(8'h03, 8'(i));
    for (int i = 0; i < 10; i++) wr_reg(8'h04, 8'(i));
    wr_reg(8'h01, 8'h20);
    wr_reg(8'h02, 8'h20);
    wr_reg(8'h03, 8'h08);
    wr_reg(8'h04, 8'h0a);
    wr_reg(8'h00, 8'h01);
    wr_reg(8'h05, 8'h01);
    for (int i = 0; i < 40; i++) begin
      wr_reg(8'($unsigned($random(seed)) % 6), 8'($unsigned($random(seed)) % 40));
    end
    host.idle();
    $display("test writes done");
    wr_reg(8'h02, 8'h0f);
    wr_reg(8'h04, 8'h01);
    wr_reg(8'h01, 8'h10);
    host.idle();
    supply_mv_i = 12'hbb7;
    settle();
    chk_bit(torch_on_o, 1'b0);
    chk_bit(low_batt_o, 1'b1);
    chk_bit(flash_on_o, 1'b0);
    supply_mv_i = 12'hbb8;
    settle();
    chk_bit(low_batt_o, 1'b0);
    chk_bit(flash_on_o, 1'b1);
    wr_reg(8'h04, 8'h00);
    host.idle();
    supply_mv_i = 12'h000;
    settle();
    chk_bit(low_batt_o, 1'b0);
    $display("test battery done");
    wr_reg(8'h01, 8'h00);
    wr_reg(8'h03, 8'h00);
    wr_reg(8'h02, 8'h10);
    host.idle();
    over_thresh_i = 1'b1;
    n = 0;
    while (safety_expired_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk_bit(n >= 4 && n <= 8, 1'b1);
    @(posedge clk_i);
    #1;
    chk_bit(torch_on_o, 1'b0);
    over_thresh_i = 1'b0;
    wr_reg(8'h02, 8'h00);
    host.idle();
    settle();
    chk_bit(safety_expired_o, 1'b0);
    $display("test safety done");
    shutdown_i = 1'b1;
    host.send(8'h01, 8'h11);
    host.idle();
    rst_model();
    chk_frame(got(), snap(1'b0));
    shutdown_i = 1'b0;
    settle();
    chk_bit(q.size() == 0, 1'b1);
    $display("test shutdown done");
    end_of_test();
  end
endmodule
`default_nettype wire
